// *** rtl/vrms_consts.svh ***
`ifndef VRMS_CONSTS_SVH
`define VRMS_CONSTS_SVH

// ********************************
// Register offsets
// ********************************
`define VRMS_OFS_OPERATION   8'h00
`define VRMS_OFS_NOMINAL     8'h04
`define VRMS_OFS_LOW_MARGIN  8'h08
`define VRMS_OFS_HIGH_MARGIN 8'h0c
`define VRMS_OFS_VENDOR_CFG  8'h10
`define VRMS_OFS_REF_STATUS  8'h14

// ********************************
// Field positions and widths
// ********************************
`define VRMS_CODE_W          9
`define VRMS_DATA_W          16
`define VRMS_ADDR_W          8
`define VRMS_OP_W            8
`define VRMS_OP_MARGIN_HI    5
`define VRMS_OP_MARGIN_LO    4
`define VRMS_CFG_MULT_HI     1
`define VRMS_CFG_MULT_LO     0
`define VRMS_STAT_BUSY_BIT   9

// ********************************
// Encodings and reset values
// ********************************
`define VRMS_SEL_NOMINAL     2'h0
`define VRMS_SEL_LOW         2'h1
`define VRMS_SEL_HIGH        2'h2
`define VRMS_MULT_NOMINAL    2'h0
`define VRMS_MULT_FAST       2'h1
`define VRMS_MULT_SLOW       2'h2
`define VRMS_RST_OPERATION   8'h00
`define VRMS_RST_CODE        9'h000
`define VRMS_RST_CFG         2'h0

// ********************************
// Timing
// ********************************
// Slew pulses from the capacitor timer per step: base rate is 8 pulses
`define VRMS_PULSES_NOMINAL  8'h07
`define VRMS_PULSES_FAST     8'h03
`define VRMS_PULSES_SLOW     8'h3f
`define VRMS_CLK_KHZ         25000
`define VRMS_CLK_PERIOD_NS   40
`define VRMS_STEP_TENTH_PCT  2
`define VRMS_DEF_RATE_PCT_MS 23
`define VRMS_DEF_STEP_CYC    ((`VRMS_STEP_TENTH_PCT * `VRMS_CLK_KHZ) / (10 * `VRMS_DEF_RATE_PCT_MS))
`define VRMS_JUMP_MAX_NS     100
`define VRMS_JUMP_MAX_CYC    (`VRMS_JUMP_MAX_NS / `VRMS_CLK_PERIOD_NS)

`endif

// *** rtl/vrms_pkg.sv ***
package vrms_pkg;
  typedef logic [8:0] vrms_code_t;
  typedef enum logic [1:0] {SLEW_BYPASS, SLEW_DEFAULT, SLEW_CAP} vrms_slew_e;
endpackage

// *** rtl/vrms_step_timer.sv ***
`timescale 1ns/1ns
`include "vrms_consts.svh"
module vrms_step_timer (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              restart,
  input  wire logic              capPulse,
  input  wire vrms_pkg::vrms_slew_e slewMode,
  input  wire logic [1:0]        multSel,
  output logic                   stepTick
);
  logic [7:0] cnt_ff;
  logic       tick_ff;
  logic [7:0] capLimit;
  logic [7:0] limit;
  logic       advance;
  logic       wrap;

  // ********************************
  // Step interval selection
  // ********************************
  assign capLimit = (multSel == `VRMS_MULT_FAST) ? `VRMS_PULSES_FAST :   // see R6
                    (multSel == `VRMS_MULT_SLOW) ? `VRMS_PULSES_SLOW :
                                                   `VRMS_PULSES_NOMINAL;
  assign limit    = (slewMode == vrms_pkg::SLEW_DEFAULT) ?
                    8'((`VRMS_DEF_STEP_CYC) - 1) : capLimit;             // see R7
  assign advance  = (slewMode == vrms_pkg::SLEW_DEFAULT) ? 1'b1 : capPulse;
  assign wrap     = advance && (cnt_ff >= limit);
  assign stepTick = tick_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? 8'h00 : (advance ? cnt_ff + 8'h01 : cnt_ff);
      tick_ff <= wrap;                                                    // see R9
    end
  end

  // ********************************
  // Checks
  // ********************************
  // Fast multiplier with a pulse every cycle puts ticks four cycles apart
  sequence s_quiet_gap;
    !tick_ff [*3];
  endsequence

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)   // see R9
    (tick_ff && !restart) |=> s_quiet_gap)
    else $error("step ticks closer than the shortest interval");
  a_default_rate: assert property (@(posedge clk) disable iff (rst)   // see R7
    (slewMode == vrms_pkg::SLEW_DEFAULT && !restart && cnt_ff == limit)
      |=> (tick_ff && cnt_ff == 8'h00))
    else $error("default rate tick not at terminal count");
endmodule

// *** rtl/vrms_top.sv ***
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "vrms_consts.svh"
// How it works
// R1 - Nominal setpoint is a 9-bit code, 0.2% of 2.4V full scale per step.
// R2 - Operation bits 5:4 pick nominal, low margin or high margin setpoint.
// R3 - Both margin bits set is illegal; reference then stays on nominal setpoint.
// R4 - New margin selection or setpoint write starts a ramp toward new target.
// R5 - Ramp moves the reference code one step up or down until it meets target.
// R6 - Config multiplier scales step rate by 1, 2 or 0.125.
// R7 - With slew pin open, ramp runs at the default 23%/ms rate.
// R8 - Slew pin strapped high bypasses ramping; reference jumps within 100ns.
// R9 - Ramp advances one step per timing tick and holds between ticks.
module vrms_top (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   regAddr,
  input  wire logic [15:0]  regWrData,
  input  wire logic         regWrStb,
  input  wire logic         regRdStb,
  output logic [15:0]       regRdData,
  input  wire logic         capStepPulse,
  input  wire logic         slewPinOpen,
  input  wire logic         slewPinHigh,
  output logic [8:0]        refCode,
  output logic              rampBusy
);

  // ********************************
  // Register storage
  // ********************************
  logic [7:0]           operation_ff;
  vrms_pkg::vrms_code_t nominalSetpoint_ff;
  vrms_pkg::vrms_code_t lowMarginSetpoint_ff;
  vrms_pkg::vrms_code_t highMarginSetpoint_ff;
  logic [1:0]           vendorCfgMult_ff;
  logic [15:0]          rdData_ff;

  // ********************************
  // Reference state
  // ********************************
  vrms_pkg::vrms_code_t refCode_ff;
  vrms_pkg::vrms_code_t nxt_refCode;
  vrms_pkg::vrms_code_t targetPrev_ff;
  logic                 busy_ff;
  logic                 nxt_busy;

  // ********************************
  // Decode wires
  // ********************************
  logic                 wrOperation;
  logic                 wrNominal;
  logic                 wrLowMargin;
  logic                 wrHighMargin;
  logic                 wrVendorCfg;
  logic [1:0]           marginSel;
  vrms_pkg::vrms_code_t targetCode;
  logic                 targetChanged;
  logic                 stepTick;
  logic                 stepUp;
  logic                 stepDown;
  vrms_pkg::vrms_slew_e slewMode;
  logic [15:0]          rdMux;
  vrms_pkg::vrms_code_t wrCode;

  assign wrCode       = regWrData[`VRMS_CODE_W-1:0];                      // see R1
  assign wrOperation  = regWrStb && (regAddr == `VRMS_OFS_OPERATION);
  assign wrNominal    = regWrStb && (regAddr == `VRMS_OFS_NOMINAL);
  assign wrLowMargin  = regWrStb && (regAddr == `VRMS_OFS_LOW_MARGIN);
  assign wrHighMargin = regWrStb && (regAddr == `VRMS_OFS_HIGH_MARGIN);
  assign wrVendorCfg  = regWrStb && (regAddr == `VRMS_OFS_VENDOR_CFG);

  // ********************************
  // Register writes
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operation_ff <= `VRMS_RST_OPERATION;
    end else if (wrOperation) begin
      operation_ff <= regWrData[`VRMS_OP_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nominalSetpoint_ff <= `VRMS_RST_CODE;
    end else if (wrNominal) begin
      nominalSetpoint_ff <= wrCode;                                       // see R1
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowMarginSetpoint_ff <= `VRMS_RST_CODE;
    end else if (wrLowMargin) begin
      lowMarginSetpoint_ff <= wrCode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      highMarginSetpoint_ff <= `VRMS_RST_CODE;
    end else if (wrHighMargin) begin
      highMarginSetpoint_ff <= wrCode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vendorCfgMult_ff <= `VRMS_RST_CFG;
    end else if (wrVendorCfg) begin
      vendorCfgMult_ff <= regWrData[`VRMS_CFG_MULT_HI:`VRMS_CFG_MULT_LO];
    end
  end

  // ********************************
  // Register reads
  // ********************************
  // Unmapped offsets read as zero so software probing the map sees no junk
  assign rdMux =
    (regAddr == `VRMS_OFS_OPERATION)   ? {8'h00, operation_ff} :
    (regAddr == `VRMS_OFS_NOMINAL)     ? {7'h00, nominalSetpoint_ff} :
    (regAddr == `VRMS_OFS_LOW_MARGIN)  ? {7'h00, lowMarginSetpoint_ff} :
    (regAddr == `VRMS_OFS_HIGH_MARGIN) ? {7'h00, highMarginSetpoint_ff} :
    (regAddr == `VRMS_OFS_VENDOR_CFG)  ? {14'h0000, vendorCfgMult_ff} :
    (regAddr == `VRMS_OFS_REF_STATUS)  ? {6'h00, busy_ff, refCode_ff} :
                                         16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 16'h0000;
    end else if (regRdStb) begin
      rdData_ff <= rdMux;
    end else begin
      rdData_ff <= 16'h0000;
    end
  end

  assign regRdData = rdData_ff;

  // ********************************
  // Target selection
  // ********************************
  assign marginSel  = operation_ff[`VRMS_OP_MARGIN_HI:`VRMS_OP_MARGIN_LO];   // see R2
  // The illegal 11 pattern falls through to nominal on purpose
  assign targetCode = (marginSel == `VRMS_SEL_LOW)  ? lowMarginSetpoint_ff :  // see R2
                      (marginSel == `VRMS_SEL_HIGH) ? highMarginSetpoint_ff :
                                                      nominalSetpoint_ff;    // see R3
  assign targetChanged = (targetCode != targetPrev_ff);                    // see R4

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      targetPrev_ff <= `VRMS_RST_CODE;
    end else begin
      targetPrev_ff <= targetCode;
    end
  end

  // ********************************
  // Slew pin mode
  // ********************************
  // A strap high wins over an open pin, in case both detectors trip
  assign slewMode = slewPinHigh ? vrms_pkg::SLEW_BYPASS :                  // see R8
                    slewPinOpen ? vrms_pkg::SLEW_DEFAULT :                 // see R7
                                  vrms_pkg::SLEW_CAP;

  vrms_step_timer u_vrms_step_timer (
    .clk      (clk),
    .rst      (rst),
    .restart  (targetChanged),
    .capPulse (capStepPulse),
    .slewMode (slewMode),
    .multSel  (vendorCfgMult_ff),
    .stepTick (stepTick)
  );

  // ********************************
  // Reference ramp
  // ********************************
  assign stepUp   = stepTick && (refCode_ff < targetCode);                 // see R5
  assign stepDown = stepTick && (refCode_ff > targetCode);                 // see R5

  always_comb begin
    nxt_refCode = refCode_ff;
    if (slewMode == vrms_pkg::SLEW_BYPASS) begin
      nxt_refCode = targetCode;                                            // see R8
    end else if (stepUp) begin
      nxt_refCode = refCode_ff + 9'h001;                                   // see R9
    end else if (stepDown) begin
      nxt_refCode = refCode_ff - 9'h001;                                   // see R9
    end
  end

  assign nxt_busy = (nxt_refCode != targetCode);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refCode_ff <= `VRMS_RST_CODE;
      busy_ff    <= 1'b0;
    end else begin
      refCode_ff <= nxt_refCode;
      busy_ff    <= nxt_busy;
    end
  end

  assign refCode  = refCode_ff;
  assign rampBusy = busy_ff;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_write_nominal;
    wrNominal && (marginSel != `VRMS_SEL_LOW) && (marginSel != `VRMS_SEL_HIGH)
      && (wrCode != nominalSetpoint_ff);
  endsequence

  sequence s_target_updated;
    targetChanged && (targetCode == $past(wrCode));
  endsequence

  a_nominal_store: assert property (                                       // see R1
    wrNominal |=> (nominalSetpoint_ff == $past(wrCode)))
    else $error("nominal setpoint not stored as 9-bit code");

  a_sel_low_path: assert property (                                        // see R2
    (marginSel == `VRMS_SEL_LOW) |-> (targetCode == lowMarginSetpoint_ff))
    else $error("low margin selection not honoured");

  a_sel_high_path: assert property (                                       // see R2
    (marginSel == `VRMS_SEL_HIGH) |-> (targetCode == highMarginSetpoint_ff))
    else $error("high margin selection not honoured");

  a_illegal_sel: assert property (                                         // see R3
    (marginSel == 2'h3) |-> (targetCode == nominalSetpoint_ff))
    else $error("illegal margin selection did not fall back to nominal");

  a_write_starts: assert property (                                        // see R4
    s_write_nominal |=> s_target_updated)
    else $error("setpoint write did not start a transition");

  a_single_step: assert property (                                         // see R5
    (slewMode != vrms_pkg::SLEW_BYPASS && refCode_ff != targetCode && stepTick)
      |=> ((refCode_ff == $past(refCode_ff) + 9'h001)
        || (refCode_ff == $past(refCode_ff) - 9'h001)))
    else $error("reference moved by other than one step");

  a_step_toward: assert property (                                         // see R5
    (slewMode != vrms_pkg::SLEW_BYPASS && stepTick && refCode_ff < targetCode)
      |=> (refCode_ff > $past(refCode_ff)))
    else $error("ramp stepped away from target");

  a_hold_no_tick: assert property (                                        // see R9
    (slewMode != vrms_pkg::SLEW_BYPASS && !stepTick) |=> $stable(refCode_ff))
    else $error("reference changed between ticks");

  a_bypass_jump: assert property (                                         // see R8
    (slewMode == vrms_pkg::SLEW_BYPASS) |-> ##[1:2] (refCode_ff == $past(targetCode)))
    else $error("bypass jump slower than allowed");

  a_busy_flag: assert property (                                           // see R5
    (refCode_ff != targetCode && $stable(targetCode) && !stepTick
      && slewMode != vrms_pkg::SLEW_BYPASS) |=> busy_ff)
    else $error("busy flag low during ramp");

  a_step_down: assert property (                                           // see R5
    (slewMode != vrms_pkg::SLEW_BYPASS && stepTick && refCode_ff > targetCode)
      |=> (refCode_ff < $past(refCode_ff))) else $error("ramp stepped up past target");

  a_hold_at_target: assert property (                                      // see R5
    (refCode_ff == targetCode) |=> $stable(refCode_ff))
    else $error("reference moved although already on target");

  a_idle_not_busy: assert property (                                       // see R5
    (refCode_ff == targetCode) |=> !busy_ff)
    else $error("busy flag high with reference on target");

  a_bypass_settled: assert property (                                      // see R8
    (slewMode == vrms_pkg::SLEW_BYPASS) |=> !busy_ff)
    else $error("busy flag high in bypass mode");

  a_sel_nominal: assert property (                                         // see R2
    (marginSel == `VRMS_SEL_NOMINAL) |-> (targetCode == nominalSetpoint_ff))
    else $error("nominal selection not honoured");

  // A new target must throw away any tick already counted for the old one
  a_restart_quiet: assert property (                                       // see R4
    targetChanged |=> !stepTick)
    else $error("step tick survived a target change");

  // Read port: data stands for one cycle only, then returns to zero
  a_rd_nominal: assert property (                                          // see R1
    (regRdStb && regAddr == `VRMS_OFS_NOMINAL)
      |=> (regRdData == {7'h00, $past(nominalSetpoint_ff)})) else $error("nominal readback wrong");

  a_rd_quiet: assert property (
    !regRdStb |=> (regRdData == 16'h0000))
    else $error("read data not zero outside a read");

endmodule

// *** test/vrms_host_model.sv ***
`timescale 1ns/1ns
module vrms_host_model (
  input  wire logic        clk,
  input  wire logic        capRun,
  input  wire logic [15:0] regRdData,
  output logic [7:0]       regAddr,
  output logic [15:0]      regWrData,
  output logic             regWrStb,
  output logic             regRdStb,
  output logic             capStepPulse
);
  initial begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end

  // ********************************
  // Capacitor timer
  // ********************************
  // Pulse every other cycle, so a step spans an exact, even cycle count
  always @(posedge clk) begin
    capStepPulse <= capRun & ~capStepPulse;
  end

  // ********************************
  // Host bus cycles
  // ********************************
  // Released lines show the inverse, so a late sample never looks right
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
endmodule

// *** test/vrms_top_test.sv ***
`timescale 1ns/1ns
`include "vrms_consts.svh"
module vrms_top_test;
  logic        clk;
  logic        rst;
  logic        capRun;
  logic        slewPinOpen;
  logic        slewPinHigh;
  logic [7:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  logic [15:0] regRdData;
  logic        capStepPulse;
  logic [8:0]  refCode;
  logic        rampBusy;
  int          nErrors;
  int          testsRun;

  vrms_top u_vrms_top (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .capStepPulse(capStepPulse), .slewPinOpen(slewPinOpen), .slewPinHigh(slewPinHigh),
    .refCode(refCode), .rampBusy(rampBusy));

  vrms_host_model u_vrms_host_model (.clk(clk), .capRun(capRun), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .capStepPulse(capStepPulse));

  // ********************************
  // Helpers
  // ********************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Jump mode: the code must land on target two edges after the write edge
  task automatic wr_jump(input logic [7:0] a, input logic [15:0] d, input logic [8:0] exp);
    u_vrms_host_model.wr(a, d);
    repeat (2) @(posedge clk);
    #1 chk("jump code", {7'h00, exp}, {7'h00, refCode});
  endtask

  // Follows a ramp: unit steps toward target, fixed gap between steps
  task automatic ramp(input logic [8:0] tgt, input int gap);
    logic [8:0] prev;
    int         n;
    int         span;
    bit         first;
    #1;
    prev = refCode;
    n = 0;
    span = 0;
    first = 1;
    while (refCode !== tgt && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
      span++;
      if (refCode !== prev) begin
        chk("step", {7'h00, (tgt > prev) ? prev + 9'h001 : prev - 9'h001}, {7'h00, refCode});
        if (!first) chk("step gap", gap[15:0], span[15:0]);
        if (refCode !== tgt) chk("busy", 16'h0001, {15'h0000, rampBusy});
        first = 0;
        span = 0;
        prev = refCode;
      end
    end
    chk("ramp end", {7'h00, tgt}, {7'h00, refCode});
    chk("idle", 16'h0000, {15'h0000, rampBusy});
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    logic [15:0] d;
    chk("reset code", 16'h0000, {7'h00, refCode});
    u_vrms_host_model.rd(`VRMS_OFS_REF_STATUS, d);
    chk("status", 16'h0000, d);
    u_vrms_host_model.rd(8'h18, d);
    chk("unmapped read", 16'h0000, d);
  endtask

  task automatic t_select;
    logic [15:0] d;
    logic [7:0]  ops [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
    logic [8:0]  want [4] = '{9'h1ff, 9'h005, 9'h123, 9'h1ff};
    @(posedge clk);
    slewPinHigh <= 1'b1;
    wr_jump(`VRMS_OFS_NOMINAL, 16'hffff, 9'h1ff);
    u_vrms_host_model.wr(`VRMS_OFS_LOW_MARGIN, 16'h0005);
    u_vrms_host_model.wr(`VRMS_OFS_HIGH_MARGIN, 16'h0123);
    u_vrms_host_model.rd(`VRMS_OFS_NOMINAL, d);
    chk("nominal readback", 16'h01ff, d);
    for (int i = 0; i < 4; i++) begin
      // Both margin bits together in the last entry must fall back to nominal
      wr_jump(`VRMS_OFS_OPERATION, {8'h00, ops[i]}, want[i]);
    end
    u_vrms_host_model.wr(8'h18, 16'h0000);
    u_vrms_host_model.rd(`VRMS_OFS_REF_STATUS, d);
    chk("status after stray write", 16'h01ff, d);
  endtask

  task automatic t_slew;
    @(posedge clk);
    slewPinHigh <= 1'b0;
    capRun <= 1'b1;
    u_vrms_host_model.wr(`VRMS_OFS_OPERATION, 16'h0000);
    u_vrms_host_model.wr(`VRMS_OFS_VENDOR_CFG, 16'h0000);
    u_vrms_host_model.wr(`VRMS_OFS_NOMINAL, 16'h01fc);
    ramp(9'h1fc, 16);
    u_vrms_host_model.wr(`VRMS_OFS_VENDOR_CFG, 16'h0001);
    u_vrms_host_model.wr(`VRMS_OFS_NOMINAL, 16'h01ff);
    ramp(9'h1ff, 8);
    u_vrms_host_model.wr(`VRMS_OFS_VENDOR_CFG, 16'h0002);
    u_vrms_host_model.wr(`VRMS_OFS_NOMINAL, 16'h01fd);
    ramp(9'h1fd, 128);
    u_vrms_host_model.wr(`VRMS_OFS_VENDOR_CFG, 16'h0000);
    u_vrms_host_model.wr(`VRMS_OFS_LOW_MARGIN, 16'h01fb);
    u_vrms_host_model.wr(`VRMS_OFS_OPERATION, 16'h0010);
    ramp(9'h1fb, 16);
    // Open pin must ignore the multiplier, so set it to slow here
    @(posedge clk);
    slewPinOpen <= 1'b1;
    u_vrms_host_model.wr(`VRMS_OFS_VENDOR_CFG, 16'h0002);
    u_vrms_host_model.wr(`VRMS_OFS_OPERATION, 16'h0000);
    ramp(9'h1fd, 217);
    // Multiplier code 3 has no meaning of its own and runs at nominal rate
    @(posedge clk);
    slewPinOpen <= 1'b0;
    u_vrms_host_model.wr(`VRMS_OFS_VENDOR_CFG, 16'h0003);
    u_vrms_host_model.wr(`VRMS_OFS_NOMINAL, 16'h01fb);
    ramp(9'h1fb, 16);
  endtask

  // ********************************
  // Clock, reset and run
  // ********************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #2000000;
    nErrors++;
    $display("watchdog expired");
    giveVerdict;
  end

  initial begin
    nErrors = 0;
    testsRun = 0;
    rst = 1'b1;
    capRun = 1'b0;
    slewPinOpen = 1'b0;
    slewPinHigh = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset;
    t_select;
    t_slew;
    giveVerdict;
  end
endmodule
